// *** bench/imd_ext_model.sv ***
// Outside controller model that ranks requests and returns a vector
`timescale 1ns/1ps
module imd_ext_model
	import imd_pkg::*;
(
	// Clock, reset and pace
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic slow_i,
	// Requests in, vector out
	input wire logic [NUM_HW-1:0] hw_req_i,
	input wire imd_fwd_s fwd_i,
	output imd_ext_s ext_o
);
	logic [5:0] vec;
	logic [2:0] age_r;
	// Every source ranked, hardware lines on top
	always_comb
	begin
		vec = 6'h00;
		if (fwd_i.software_request_bits[0])
			vec = 6'h01;
		if (fwd_i.software_request_bits[1])
			vec = 6'h02;
		if (fwd_i.counter_match_request)
			vec = 6'h07;
		if (fwd_i.perf_counter_request)
			vec = 6'h08;
		if (fwd_i.debug_channel_request)
			vec = 6'h09;
		for (int i = 0; i < NUM_HW; i++)
			if (hw_req_i[i])
				vec = 6'(10 + i);
	end
	////////////////////////////////////////////////////////////////////
	// Slow answers need a request now and also three cycles earlier
	always_ff @(posedge mclk_i or negedge rst_b_i)
		if (!rst_b_i)
		begin
			age_r <= 3'h0;
			ext_o <= '0;
		end
		else
		begin
			age_r <= {age_r[1:0], vec != 6'h00};
			ext_o.valid <= (vec != 6'h00) && (!slow_i || age_r[2]);
			// Idle vector toggles so a stale value cannot pass
			ext_o.vector <= (vec != 6'h00) ? vec : ~ext_o.vector;
			ext_o.requested_priority_level <= vec;
		end
endmodule // imd_ext_model

// *** bench/testbench.sv ***
// Self-checking bench for the interrupt mode dispatch block
`timescale 1ns/1ps
module testbench
	import imd_pkg::*;
;
	logic mclk_i = 0, rst_b_i = 0, hsel = 0, hwrite = 0, slow = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
	logic [1:0] htrans = 0;
	logic [5:0] hw = 0, current_priority_level;
	logic cm = 0, pc = 0, dc = 0, hready, disp, irq;
	logic [63:0] epc;
	logic [31:0] seed = 32'h0000_4e0b;
	imd_ext_s ext;
	imd_fwd_s fwd;
	imd_mode_e mode;
	int err_count = 0, total_checks = 0, cyc = 0;

	initial
	begin
		forever #10 mclk_i = ~mclk_i;
	end

	imd_dispatch dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
		.hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(),
		.hw_req_i(hw), .counter_match_request_i(cm),
		.perf_counter_request_i(pc), .debug_channel_request_i(dc),
		.ext_i(ext), .fwd_o(fwd), .mode_o(mode), .dispatch_o(disp),
		.epc_o(epc), .current_priority_level_o(current_priority_level), .irq_o(irq));
	imd_ext_model peer (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
		.slow_i(slow), .hw_req_i(hw), .fwd_i(fwd), .ext_o(ext));
	////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic results();
		if (err_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [63:0] e, g);
		total_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask

	// Hang guard well past the planned run
	always @(posedge mclk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_count++;
			results();
		end
	end

	task automatic bus(input logic w, logic [7:0] a, logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge mclk_i);
		while (hready !== 1'b1)
			@(posedge mclk_i);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge mclk_i);
		while (hready !== 1'b1)
			@(posedge mclk_i);
		q = hrdata;
	endtask
	////////////////////////////////////////////////////////////////////
	// Reference: mode, vector and exception PC from config and control
	task automatic run(input int cfg, ctl, input logic [63:0] vb);
		logic [31:0] r;
		logic [7:0] pend;
		logic [63:0] b;
		logic [29:0] off;
		int vs, iv, boot_exception_vectors, ex, vec, n;
		imd_mode_e m;
		r = rnd();
		pend = {r[9:4], 2'(r[12:11] % 3 + 1)};
		{hw, cm, pc, dc, slow} <= {r[9:4], r[3:0]};
		bus(1, OFF_CONFIG, 32'(cfg));
		bus(1, OFF_CTRL, 32'(ctl));
		bus(1, OFF_VBASE_LO, vb[31:0]);
		bus(1, OFF_VBASE_HI, vb[63:32]);
		bus(1, OFF_PEND, {30'h0, pend[1:0]});
		bus(1, OFF_MASK, {31'h0, r[10]});
		bus(0, OFF_CTRL, 0);
		chk("ctrl", 64'(ctl), 64'(q));
		repeat (6) @(posedge mclk_i);
		vs = (cfg >> 4) & 31;
		iv = (ctl >> 1) & 1;
		boot_exception_vectors = (ctl >> 2) & 1;
		ex = ctl & 1;
		m = IMD_COMPAT;
		if (ex && vs && iv && !boot_exception_vectors)
			m = IMD_EXT;
		else if ((cfg & 1) && !ex && vs && iv && !boot_exception_vectors)
			m = IMD_VECT;
		chk("mode", 64'(m), 64'(mode));
		chk("fwd", (m == IMD_EXT) ? 64'({pend[1:0], r[3:1]}) : 64'h0,
			64'(fwd));
		vec = 0;
		if (m == IMD_EXT)
			vec = r[1] ? 9 : r[2] ? 8 : r[3] ? 7 : pend[1] ? 2 : 1;
		for (int i = 0; i < 8; i++)
			if (pend[i])
				vec = (m == IMD_EXT && i > 1) ? i + 8 : (m == IMD_EXT) ?
					vec : i + 1;
		// Compatibility with the select bit set always lands on 0x200
		off = iv == 0 ? VOFF_GEN : (m == IMD_COMPAT) ? VOFF_IV :
			VOFF_IV + 30'(vec * (vs << 5));
		b = boot_exception_vectors ? BOOT_VBASE : vb;
		bus(1, OFF_CTRL, 32'(ctl | 8));
		n = 0;
		do
		begin
			@(posedge mclk_i);
			n++;
		end
		while (disp !== 1'b1 && n < 40);
		chk("dispatch", 1, 64'(disp));
		@(posedge mclk_i);
		chk("epc", {b[63:30], b[29:0] + off}, epc);
		if (m == IMD_EXT)
			chk("level", 64'(vec), 64'(current_priority_level));
		repeat (2) @(posedge mclk_i);
		chk("irq", 64'(r[10]), 64'(irq));
		bus(1, OFF_STATUS, 32'h3);
		{hw, cm, pc, dc} <= '0;
		bus(1, OFF_PEND, 32'h0);
		chk("irq clear", 0, 64'(irq));
	endtask

	initial
	begin
		repeat (5) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		@(posedge mclk_i);
		chk("mode", 64'(IMD_COMPAT), 64'(mode));
		bus(0, OFF_CONFIG, 0);
		chk("config", 64'(RST_CONFIG), 64'(q));
		bus(0, OFF_CTRL, 0);
		chk("ctrl", 64'(RST_CTRL), 64'(q));
		bus(0, 8'hfc, 0);
		chk("unmapped", 0, 64'(q));
		run(1, 4, RST_VBASE);
		run(32'h11, 0, 64'h0123_4567_3fff_f000);
		run(1, 2, RST_VBASE);
		run(32'h51, 6, RST_VBASE);
		// Odd rounds set vectored support, late rounds external mode
		for (int k = 0; k < 12; k++)
			run(((rnd() % 31 + 1) << 4) | (k & 1), k < 6 ? 2 : 3,
				{rnd(), 32'h3fff_f000 | (rnd() & 32'hc000_0000)});
		results();
	end
endmodule // testbench

// *** hw/imd_dispatch.sv ***
// Interrupt mode selection and dispatch with AHB-Lite register slave
//
// The implementer's own choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
// Function
// - Vectored mode needs vectored_support_flag=1, ext=0, spacing nonzero, ivsel=1, boot=0
// - Vectored mode: priority encoder picks highest pending request's vector
// - External mode needs ext=1, spacing nonzero, ivsel=1, boot=0
// - External mode forwards software, timer, perf, debug requests outward
// - Vectored and external modes dispatch by hardware, no software decode
// - Reset enters compatibility mode, interrupts not vectored
// - Compatibility dispatch at 0x180 if ivsel=0, else 0x200
// - Exception PC is base plus offset, no carry from bit 29 to 30
module imd_dispatch
	import imd_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// Hardware requests and counters, asynchronous
	input wire logic [NUM_HW-1:0] hw_req_i,
	input wire logic counter_match_request_i,
	input wire logic perf_counter_request_i,
	input wire logic debug_channel_request_i,
	// Outside controller link, same clock
	input wire imd_ext_s ext_i,
	output imd_fwd_s fwd_o,
	// Dispatch result
	output imd_mode_e mode_o,
	output logic dispatch_o,
	output logic [63:0] epc_o,
	output logic [IPL_W-1:0] current_priority_level_o,
	// Interrupt
	output logic irq_o
);
	////////////////////////////////////////////////////////////////////
	logic [31:0] config_r;
	logic [31:0] ctrl_r;
	logic [63:0] vbase_r;
	logic [1:0] sw_r;
	logic [NUM_HW+2:0] sync1_r;
	logic [NUM_HW+2:0] sync2_r;
	logic [ST_W-1:0] status_r;
	logic [ST_W-1:0] mask_r;
	logic [VEC_W-1:0] vecnum_r;
	imd_mode_e mode_nxt;
	logic [NUM_REQ-1:0] pend;
	logic [VEC_W-1:0] enc_vec;
	logic enc_hit;
	logic [4:0] vs;
	logic vs_nz;
	logic [29:0] voff;
	logic [63:0] vbase;
	logic dp_ph_r;
	logic dp_wr_r;
	logic [7:0] dp_addr_r;
	logic trig;
	logic take;

	assign vs = config_r[CFG_VS_LSB +: CFG_VS_W];
	assign vs_nz = (vs != 5'h00);

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers; first stage read only by the second
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
		end
		else
		begin
			sync1_r <= {debug_channel_request_i, perf_counter_request_i,
				counter_match_request_i, hw_req_i};
			sync2_r <= sync1_r;
		end
	end

	// Pending vector: hw[5:0] above sw[1:0], same as the IP order
	assign pend = {sync2_r[NUM_HW-1:0], sw_r};

	////////////////////////////////////////////////////////////////////
	// Mode qualification
	always_comb
	begin
		mode_nxt = IMD_COMPAT;
		if (ctrl_r[CTL_EICM_BIT] && vs_nz && ctrl_r[CTL_IVSEL_BIT] &&
			!ctrl_r[CTL_BOOT_BIT])
			mode_nxt = IMD_EXT;
		else if (config_r[CFG_VECTORED_SUPPORT_FLAG_BIT] && !ctrl_r[CTL_EICM_BIT] && vs_nz &&
			ctrl_r[CTL_IVSEL_BIT] && !ctrl_r[CTL_BOOT_BIT])
			mode_nxt = IMD_VECT;
	end

	// Priority encoder: highest line wins, vector is line number + 1
	always_comb
	begin
		enc_vec = '0;
		enc_hit = 1'b0;
		for (int i = 0; i < NUM_REQ; i++)
			if (pend[i])
			begin
				enc_vec = VEC_W'(i + 1);
				enc_hit = 1'b1;
			end
	end

	// Offset and base selection
	always_comb
	begin
		vbase = ctrl_r[CTL_BOOT_BIT] ? BOOT_VBASE : vbase_r;
		if (!ctrl_r[CTL_IVSEL_BIT])
			voff = VOFF_GEN;
		else if (mode_o == IMD_COMPAT)
			voff = VOFF_IV;
		else
			voff = VOFF_IV + 30'({vecnum_r, 5'h00} * vs);
	end

	assign trig = ctrl_r[CTL_TRIG_BIT] && !dispatch_o;
	assign take = trig && (mode_o == IMD_EXT ? ext_i.valid :
		mode_o == IMD_VECT ? enc_hit : (|pend));

	////////////////////////////////////////////////////////////////////
	// Mode register and dispatch: vector latched, then PC formed
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			mode_o <= IMD_COMPAT;
			dispatch_o <= 1'b0;
			vecnum_r <= '0;
			epc_o <= '0;
			current_priority_level_o <= '0;
		end
		else
		begin
			mode_o <= mode_nxt;
			dispatch_o <= take;
			if (take)
			begin
				vecnum_r <= (mode_o == IMD_EXT) ? ext_i.vector : enc_vec;
				if (mode_o == IMD_EXT)
					current_priority_level_o <= ext_i.requested_priority_level;
			end
			if (dispatch_o)
				epc_o <= {vbase[63:30], vbase[29:0] + voff};
		end
	end

	// Forward requests outward only in external mode
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			fwd_o <= '0;
		else if (mode_o == IMD_EXT)
			fwd_o <= {sw_r, sync2_r[NUM_HW], sync2_r[NUM_HW+1],
				sync2_r[NUM_HW+2]};
		else
			fwd_o <= '0;
	end

	////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: zero wait states, always OKAY
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			dp_ph_r <= 1'b0;
			dp_wr_r <= 1'b0;
			dp_addr_r <= '0;
		end
		else if (hready_i)
		begin
			dp_ph_r <= hsel_i && htrans_i[1];
			dp_wr_r <= hwrite_i;
			dp_addr_r <= haddr_i[7:0];
		end
	end

	// Register writes
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			config_r <= RST_CONFIG;
			ctrl_r <= RST_CTRL;
			vbase_r <= RST_VBASE;
			sw_r <= '0;
			mask_r <= '0;
		end
		else
		begin
			if (dispatch_o)
				ctrl_r[CTL_TRIG_BIT] <= 1'b0;
			if (dp_ph_r && dp_wr_r)
				unique case (dp_addr_r)
					OFF_CONFIG: config_r <= hwdata_i;
					OFF_CTRL: ctrl_r <= hwdata_i;
					OFF_VBASE_LO: vbase_r[31:0] <= hwdata_i;
					OFF_VBASE_HI: vbase_r[63:32] <= hwdata_i;
					OFF_PEND: sw_r <= hwdata_i[1:0];
					OFF_MASK: mask_r <= hwdata_i[ST_W-1:0];
					default: ;
				endcase
		end
	end

	// Sticky status; set wins over write-one-to-clear
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			status_r <= '0;
		else
		begin
			if (dp_ph_r && dp_wr_r && dp_addr_r == OFF_STATUS)
				status_r <= status_r & ~hwdata_i[ST_W-1:0];
			if (dispatch_o)
				status_r[ST_DISP_BIT] <= 1'b1;
			if (mode_nxt != mode_o)
				status_r[ST_MODE_BIT] <= 1'b1;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(status_r & mask_r);
	end

	// Read data registered at the address phase for flop-driven outputs
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			hrdata_o <= '0;
		else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i)
			unique case (haddr_i[7:0])
				OFF_CONFIG: hrdata_o <= config_r;
				OFF_CTRL: hrdata_o <= ctrl_r;
				OFF_VBASE_LO: hrdata_o <= vbase_r[31:0];
				OFF_VBASE_HI: hrdata_o <= vbase_r[63:32];
				OFF_PEND: hrdata_o <= 32'(pend);
				OFF_DISPATCH: hrdata_o <= 32'({current_priority_level_o,
					vecnum_r, mode_o});
				OFF_EPC_LO: hrdata_o <= epc_o[31:0];
				OFF_EPC_HI: hrdata_o <= epc_o[63:32];
				OFF_STATUS: hrdata_o <= 32'(status_r);
				OFF_MASK: hrdata_o <= 32'(mask_r);
				OFF_FWD: hrdata_o <= 32'(fwd_o);
				default: hrdata_o <= '0;
			endcase
	end

	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end
		else
		begin
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	property p_vect_qual;
		@(posedge mclk_i) disable iff (!rst_b_i)
		(mode_o == IMD_VECT) |-> $past(config_r[CFG_VECTORED_SUPPORT_FLAG_BIT] &&
			!ctrl_r[CTL_EICM_BIT] && vs_nz && ctrl_r[CTL_IVSEL_BIT] &&
			!ctrl_r[CTL_BOOT_BIT]);
	endproperty
	a_vect_qual: assert property (p_vect_qual)
		else $error("vectored mode without its conditions");

	property p_ext_mode;
		@(posedge mclk_i) disable iff (!rst_b_i)
		(mode_nxt == IMD_EXT) |=> (mode_o == IMD_EXT);
	endproperty
	a_ext_mode: assert property (p_ext_mode)
		else $error("external mode not entered");

	property p_compat;
		@(posedge mclk_i) disable iff (!rst_b_i)
		(!ctrl_r[CTL_IVSEL_BIT] || ctrl_r[CTL_BOOT_BIT] || !vs_nz) |=>
			(mode_o == IMD_COMPAT);
	endproperty
	a_compat: assert property (p_compat)
		else $error("compatibility mode not held");

	property p_fwd_off;
		@(posedge mclk_i) disable iff (!rst_b_i)
		(mode_o != IMD_EXT) |=> (fwd_o == '0);
	endproperty
	a_fwd_off: assert property (p_fwd_off)
		else $error("requests forwarded outside external mode");

	property p_fwd_sw;
		@(posedge mclk_i) disable iff (!rst_b_i)
		(mode_o == IMD_EXT) |=>
			(fwd_o.software_request_bits == $past(sw_r));
	endproperty
	a_fwd_sw: assert property (p_fwd_sw)
		else $error("software requests not forwarded");

	property p_vec_gen;
		@(posedge mclk_i) disable iff (!rst_b_i)
		(dispatch_o && !ctrl_r[CTL_IVSEL_BIT] && !ctrl_r[CTL_BOOT_BIT]) |=>
			(epc_o[29:0] == $past(vbase_r[29:0]) + VOFF_GEN);
	endproperty
	a_vec_gen: assert property (p_vec_gen)
		else $error("general offset wrong");

	property p_no_carry;
		@(posedge mclk_i) disable iff (!rst_b_i)
		dispatch_o |=> (epc_o[63:30] == $past(vbase[63:30]));
	endproperty
	a_no_carry: assert property (p_no_carry)
		else $error("carry reached bit 30");

	property p_ext_vec;
		@(posedge mclk_i) disable iff (!rst_b_i)
		(take && mode_o == IMD_EXT) |=> (vecnum_r == $past(ext_i.vector));
	endproperty
	a_ext_vec: assert property (p_ext_vec)
		else $error("external vector not taken");

	property p_enc;
		@(posedge mclk_i) disable iff (!rst_b_i)
		(take && mode_o == IMD_VECT && pend[NUM_REQ-1]) |=>
			(vecnum_r == VEC_W'(NUM_REQ));
	endproperty
	a_enc: assert property (p_enc)
		else $error("top request not chosen");

	c_vect: cover property (@(posedge mclk_i) mode_o == IMD_VECT && dispatch_o);
	c_ext: cover property (@(posedge mclk_i) mode_o == IMD_EXT && dispatch_o);
	c_compat: cover property (@(posedge mclk_i)
		mode_o == IMD_COMPAT && dispatch_o);
	c_irq: cover property (@(posedge mclk_i) irq_o);
endmodule // imd_dispatch

// *** inc/imd_pkg.sv ***
// Package: constants and types for the interrupt mode dispatch block
package imd_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CONFIG = 8'h00;
	localparam logic [7:0] OFF_CTRL = 8'h04;
	localparam logic [7:0] OFF_VBASE_LO = 8'h08;
	localparam logic [7:0] OFF_VBASE_HI = 8'h0c;
	localparam logic [7:0] OFF_PEND = 8'h10;
	localparam logic [7:0] OFF_DISPATCH = 8'h14;
	localparam logic [7:0] OFF_EPC_LO = 8'h18;
	localparam logic [7:0] OFF_EPC_HI = 8'h1c;
	localparam logic [7:0] OFF_STATUS = 8'h20;
	localparam logic [7:0] OFF_MASK = 8'h24;
	localparam logic [7:0] OFF_FWD = 8'h28;
	// Config field positions
	localparam int CFG_VECTORED_SUPPORT_FLAG_BIT = 0;
	localparam int CFG_VS_LSB = 4;
	localparam int CFG_VS_W = 5;
	// Control field positions
	localparam int CTL_EICM_BIT = 0;
	localparam int CTL_IVSEL_BIT = 1;
	localparam int CTL_BOOT_BIT = 2;
	localparam int CTL_TRIG_BIT = 3;
	// Reset values and boot vector base
	localparam logic [31:0] RST_CONFIG = 32'h0000_0001;
	localparam logic [31:0] RST_CTRL = 32'h0000_0004;
	localparam logic [63:0] RST_VBASE = 64'hffff_ffff_8000_0000;
	localparam logic [63:0] BOOT_VBASE = 64'hffff_ffff_bfc0_0200;
	// Vector offsets
	localparam logic [29:0] VOFF_GEN = 30'h0000_0180;
	localparam logic [29:0] VOFF_IV = 30'h0000_0200;
	// Request layout
	localparam int NUM_HW = 6;
	localparam int NUM_REQ = 8;
	localparam int VEC_W = 6;
	localparam int IPL_W = 6;
	// Interrupt status bits
	localparam int ST_DISP_BIT = 0;
	localparam int ST_MODE_BIT = 1;
	localparam int ST_W = 2;

	typedef enum logic [1:0] {
		IMD_COMPAT = 2'b00,
		IMD_VECT = 2'b01,
		IMD_EXT = 2'b11
	} imd_mode_e;

	// Requests sent to the outside controller
	typedef struct packed {
		logic [1:0] software_request_bits;
		logic counter_match_request;
		logic perf_counter_request;
		logic debug_channel_request;
	} imd_fwd_s;

	// Vector and level returned by the outside controller
	typedef struct packed {
		logic valid;
		logic [VEC_W-1:0] vector;
		logic [IPL_W-1:0] requested_priority_level;
	} imd_ext_s;
endpackage
